// *** isp_pkg.sv ***
// constants and types for the subaddressed i2c register port
//
// Operation
// - device answers write address byte c8 and read address byte c9
// - device never drives or stretches the clock line
// - matching write address after start is acknowledged in the ninth clock
// - first byte after write address loads the pointer at its acknowledge
// - byte after a pointer byte goes to pending storage, not active register
// - odd bytes are pointers, even bytes data, pairing repeats without limit
// - pending data is kept, unapplied, across repeated starts to any device
// - on stop all pending data is copied to the active registers at once
// - a read returns only the register selected by the current pointer
// - read address is acknowledged, then selected byte shifts out msb first
// - clocks after the single read byte see data line released high
// - during a read only the read address is acknowledged
// - pointer is kept between transactions; new pointer needs a write
// - write-only register read returns pending value if written since stop
// - discharge count register read returns the active value
// - without pending interrupt, alarm status is sampled at read acknowledge
// - alarm asserts interrupt low and freezes the alarm status register
// - committed one in bit 0 of interrupt-clear register clears interrupt
// - after clearing, status captures at read acknowledge or next interrupt
package isp_pkg;
  localparam logic [7:0] WR_ADDR   = 8'hc8;
  localparam logic [7:0] RD_ADDR   = 8'hc9;
  localparam logic [7:0] SUB_A     = 8'h01;
  localparam logic [7:0] SUB_B     = 8'h02;
  localparam logic [7:0] SUB_C     = 8'h03;
  localparam logic [7:0] SUB_D     = 8'h04;
  localparam logic [7:0] SUB_E     = 8'h05;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] NO_DATA   = 8'h00;
  localparam logic [3:0] BIT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_ONE   = 4'h1;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [1:0] IDX_A     = 2'h0;
  localparam logic [1:0] IDX_B     = 2'h1;
  localparam logic [1:0] IDX_C     = 2'h2;
  localparam logic [1:0] IDX_E     = 2'h3;
  localparam int         LOCS      = 4;
  localparam int         CLR_BIT   = 0;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_WPTR, PH_WDATA, PH_RDATA, PH_RDONE} isp_phase_t;
endpackage

// *** isp_port.sv ***
// subaddressed i2c register port with pending commands and alarm latch
`timescale 1ns/1ps
`default_nettype none
module isp_port
  import isp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclClk,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [7:0] alarmStatus,
  input  wire logic       alarmEvent,
  output logic            irqN,
  output logic [7:0]      cmdA,
  output logic [7:0]      cmdB,
  output logic [7:0]      cmdC,
  output logic [7:0]      cmdE,
  output logic            cmdUpdate
);
  import isp_pkg::*;

  function automatic logic isStore(input logic [7:0] p);
    isStore = (p == SUB_A) || (p == SUB_B) || (p == SUB_C) || (p == SUB_E);
  endfunction

  function automatic logic [1:0] locIdx(input logic [7:0] p);
    case (p)
      SUB_A:   locIdx = IDX_A;
      SUB_B:   locIdx = IDX_B;
      SUB_C:   locIdx = IDX_C;
      default: locIdx = IDX_E;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain, rising scl: sample data line
  logic       sdaAtRise;
  logic [7:0] rxShift;

  always_ff @(posedge sclClk)
  begin
    sdaAtRise <= sdaIn;
    rxShift   <= {rxShift[6:0], sdaIn};
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain, falling scl: framing, ack and transmit
  isp_phase_t phase, next_phase;
  logic [3:0] bitCnt, next_bitCnt;
  logic       sdaDrive, next_sdaDrive;
  logic [7:0] txShift, next_txShift;
  logic [7:0] pointer, next_pointer;
  logic [7:0] dataByte, next_dataByte;
  // two-state: the far side only watches for changes, any start value works
  bit         dataTgl, next_dataTgl;
  logic       rstLinkMeta, rstLink;
  logic [7:0] rdMeta, rdSync;
  logic [7:0] readByte;
  logic       startSeen;

  // data only moves while scl is low, so a high-to-low change between edges is start
  assign startSeen = sdaAtRise & ~sdaIn;

  always_comb
  begin
    next_phase    = phase;
    next_bitCnt   = bitCnt;
    next_sdaDrive = sdaDrive;
    next_txShift  = txShift;
    next_pointer  = pointer;
    next_dataByte = dataByte;
    next_dataTgl  = dataTgl;
    if (rstLink)
    begin
      next_phase    = PH_IDLE;
      next_bitCnt   = BIT_ZERO;
      next_sdaDrive = 1'b0;
      next_pointer  = PTR_RESET;
    end
    else if (startSeen)
    begin
      next_phase    = PH_ADDR;
      next_bitCnt   = BIT_ZERO;
      next_sdaDrive = 1'b0;
    end
    else if (phase != PH_IDLE)
    begin
      if (bitCnt < LAST_BIT)
      begin
        next_bitCnt = bitCnt + BIT_ONE;
        if (phase == PH_RDATA)
        begin
          next_txShift  = {txShift[6:0], 1'b1};
          next_sdaDrive = ~txShift[6];
        end
      end
      else if (bitCnt == LAST_BIT)
      begin
        next_bitCnt   = ACK_BIT;
        next_sdaDrive = 1'b0;
        case (phase)
          PH_ADDR:
          begin
            if (rxShift == WR_ADDR)
            begin
              next_sdaDrive = 1'b1;
              next_phase    = PH_WPTR;
            end
            else if (rxShift == RD_ADDR)
            begin
              next_sdaDrive = 1'b1;
              next_phase    = PH_RDATA;
            end
            else
            begin
              next_phase = PH_IDLE;
            end
          end
          PH_WPTR:
          begin
            next_sdaDrive = 1'b1;
            next_pointer  = rxShift;
            next_phase    = PH_WDATA;
          end
          PH_WDATA:
          begin
            // data byte then back to pointer
            next_sdaDrive = 1'b1;
            next_dataByte = rxShift;
            next_dataTgl  = ~dataTgl;
            next_phase    = PH_WPTR;
          end
          PH_RDATA: next_phase = PH_RDONE;
          default:  next_phase = phase;
        endcase
      end
      else
      begin
        next_bitCnt   = BIT_ZERO;
        next_sdaDrive = 1'b0;
        // load selected byte after read ack
        if (phase == PH_RDATA)
        begin
          next_txShift  = rdSync;
          next_sdaDrive = ~rdSync[7];
        end
      end
    end
  end

  always_ff @(negedge sclClk)
  begin
    rstLinkMeta <= rst;
    rstLink     <= rstLinkMeta;
    // selected byte is quasi-static once the pointer is set
    rdMeta      <= readByte;
    rdSync      <= rdMeta;
    phase       <= next_phase;
    bitCnt      <= next_bitCnt;
    sdaDrive    <= next_sdaDrive;
    txShift     <= next_txShift;
    pointer     <= next_pointer;
    dataByte    <= next_dataByte;
    dataTgl     <= next_dataTgl;
  end

  sequence byteDone(isp_phase_t p);
    phase == p && bitCnt == LAST_BIT && !startSeen;
  endsequence

  sequence readAckEnd;
    phase == PH_RDATA && bitCnt == ACK_BIT && !startSeen;
  endsequence

  AST_WR_ADDR_ACK: assert property (@(negedge sclClk) disable iff (rstLink)
    byteDone(PH_ADDR) ##0 rxShift == WR_ADDR |=> sdaDrive && phase == PH_WPTR)
    else $error("write address not acknowledged");
  AST_PTR_LOAD: assert property (@(negedge sclClk) disable iff (rstLink)
    byteDone(PH_WPTR) |=> pointer == $past(rxShift) && phase == PH_WDATA)
    else $error("pointer not loaded at its ack");
  AST_DATA_PASS: assert property (@(negedge sclClk) disable iff (rstLink)
    byteDone(PH_WDATA) |=> dataTgl != $past(dataTgl) && phase == PH_WPTR)
    else $error("data byte not handed over");
  AST_TX_MSB: assert property (@(negedge sclClk) disable iff (rstLink)
    readAckEnd |=> sdaDrive == ~$past(rdSync[7]) ##1 sdaDrive == ~$past(rdSync[6], 2))
    else $error("read byte not sent msb first");
  AST_READ_QUIET: assert property (@(negedge sclClk) disable iff (rstLink)
    phase == PH_RDONE |-> !sdaDrive)
    else $error("data line driven after read byte");

  ////////////////////////////////////////////////////////////////////////////
  // system domain: pin synchronisers and event detect
  logic sclMeta, sclSync, sdaMeta, sdaSync, sdaPrev;
  logic tglMeta, tglSync, tglPrev;
  logic stopSeen, startSys, dataEvt;

  always_ff @(posedge sys_clk)
  begin
    sclMeta <= sclClk;
    sclSync <= sclMeta;
    sdaMeta <= sdaIn;
    sdaSync <= sdaMeta;
    sdaPrev <= sdaSync;
    tglMeta <= dataTgl;
    tglSync <= tglMeta;
    tglPrev <= tglSync;
  end

  assign stopSeen = sclSync & sdaSync & ~sdaPrev;
  assign startSys = sclSync & ~sdaSync & sdaPrev;
  assign dataEvt  = tglSync ^ tglPrev;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: pending, active, alarm and read selection
  logic [7:0] pend [LOCS];
  logic [7:0] act  [LOCS];
  logic [7:0] next_pend [LOCS];
  logic [7:0] next_act  [LOCS];
  logic [3:0] modified, next_modified;
  logic       next_cmdUpdate;
  logic       irqPend, next_irqPend;
  logic [7:0] alarmLatch, next_alarmLatch;
  logic [7:0] next_readByte;
  logic       linkUp, next_linkUp;
  logic       irqClr;
  logic [7:0] statusView;

  always_comb
  begin
    next_pend      = pend;
    next_act       = act;
    next_modified  = modified;
    next_cmdUpdate = 1'b0;
    irqClr         = 1'b0;
    next_linkUp    = linkUp | startSys;
    if (stopSeen)
    begin
      for (int i = 0; i < LOCS; i++)
      begin
        if (modified[i])
        begin
          next_act[i] = pend[i];
        end
      end
      next_modified  = '0;
      next_cmdUpdate = 1'b1;
      irqClr = modified[IDX_E] & pend[IDX_E][CLR_BIT];
    end
    // held here until a stop, whatever else is addressed
    else if (dataEvt && isStore(pointer))
    begin
      next_pend[locIdx(pointer)]     = dataByte;
      next_modified[locIdx(pointer)] = 1'b1;
    end
    // a new alarm beats a clear in the same cycle
    next_irqPend    = alarmEvent | (irqPend & ~irqClr);
    next_alarmLatch = alarmLatch;
    if (alarmEvent && (!irqPend || irqClr))
    begin
      next_alarmLatch = alarmStatus;
    end
    // live status unless an interrupt pends, else the latch; captured by the link at the read ack
    statusView = irqPend ? alarmLatch : alarmStatus;
    case (pointer)
      // pending if written since stop, else active
      SUB_A, SUB_B, SUB_E:
        next_readByte = modified[locIdx(pointer)] ? pend[locIdx(pointer)] : act[locIdx(pointer)];
      SUB_C:   next_readByte = act[IDX_C];
      SUB_D:   next_readByte = statusView;
      default: next_readByte = NO_DATA;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend       <= '{default: CMD_RESET};
      act        <= '{default: CMD_RESET};
      modified   <= '0;
      cmdUpdate  <= 1'b0;
      irqPend    <= 1'b0;
      alarmLatch <= CMD_RESET;
      readByte   <= NO_DATA;
      linkUp     <= 1'b0;
    end
    else
    begin
      pend       <= next_pend;
      act        <= next_act;
      modified   <= next_modified;
      cmdUpdate  <= next_cmdUpdate;
      irqPend    <= next_irqPend;
      alarmLatch <= next_alarmLatch;
      readByte   <= next_readByte;
      linkUp     <= next_linkUp;
    end
  end

  // no clock drive exists; data line is open drain
  assign sdaOut = 1'b0;
  // link state is unknown until its first start
  assign sdaOe  = sdaDrive & linkUp;
  assign irqN   = ~irqPend;
  assign cmdA   = act[IDX_A];
  assign cmdB   = act[IDX_B];
  assign cmdC   = act[IDX_C];
  assign cmdE   = act[IDX_E];

  AST_COMMIT: assert property (@(posedge sys_clk) disable iff (rst)
    stopSeen && modified[IDX_B] |=> cmdB == $past(pend[IDX_B]) && modified == 4'h0)
    else $error("pending data not committed on stop");
  AST_IRQ_SET: assert property (@(posedge sys_clk) disable iff (rst)
    alarmEvent && !irqPend |=> !irqN && alarmLatch == $past(alarmStatus))
    else $error("alarm did not latch");
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (rst)
    irqPend && !irqClr |=> $stable(alarmLatch) && !irqN)
    else $error("alarm latch moved while frozen");
  AST_IRQ_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    stopSeen && modified[IDX_E] && pend[IDX_E][CLR_BIT] && !alarmEvent |=> irqN)
    else $error("interrupt not cleared");
  AST_RD_PEND: assert property (@(posedge sys_clk) disable iff (rst)
    pointer == SUB_A && modified[IDX_A] && $stable(pointer) |=> readByte == $past(pend[IDX_A]))
    else $error("pending value not offered for read");
endmodule
`default_nettype wire

// *** isp_master.sv ***
// bus master model for the i2c link
`timescale 1ns/1ps
`default_nettype none
module isp_master
(
  output logic      sclClk,
  output logic      sdaDrv,
  input  wire logic sdaLine
);
  // clock stands high between frames; released data reads high via the pull-up
  initial
  begin
    sclClk = 1'b1;
    sdaDrv = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // data moves early in the low half, 60 ns clear of the rise, so the
  // synchronised pins never show it as a false stop: 160 ns per clock
  task automatic bitx(input logic b, output logic s);
    #20 sdaDrv = b;
    #60 sclClk = 1'b1;
    #40 s = sdaLine;
    #40 sclClk = 1'b0;
  endtask
  task automatic start();
    if (sclClk)
      #40 sclClk = 1'b0;
    #20 sdaDrv = 1'b1;
    #60 sclClk = 1'b1;
    // held longer than a system clock so the start is seen there as well
    #80 sdaDrv = 1'b0;
    #80 sclClk = 1'b0;
  endtask
  task automatic stop();
    #20 sdaDrv = 1'b0;
    #60 sclClk = 1'b1;
    #80 sdaDrv = 1'b1;
    #80;
  endtask
  // msb first; ninth clock released for the receiver
  task automatic wb(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], s);
    bitx(1'b1, ack);
  endtask
  // master always answers nack, only one byte comes back anyway
  task automatic rb(output logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(1'b1, a);
  endtask
endmodule
`default_nettype wire

// *** isp_port_tb.sv ***
// self-checking bench: master model, reference model, port
`timescale 1ns/1ps
`default_nettype none
module isp_port_tb;
  import isp_pkg::*;
  logic       sys_clk, rst, sclClk, sdaDrv, sdaIn, sdaOe, alarmEvent, irqN, cmdUpdate, ack;
  logic       sdaOut;
  logic [7:0] alarmStatus, cmdA, cmdB, cmdC, cmdE, d, ptr, lat;
  int         miscompares, checks, updates, stops, pos, irqM;
  int         act [8];
  int         pend [8];
  int         wr [8];
  logic [7:0] locs [5] = '{SUB_A, SUB_B, SUB_C, SUB_E, 8'h07};
  // open drain wire with pull-up
  assign sdaIn = sdaDrv & ~sdaOe;
  isp_port isp_port_i (.sys_clk(sys_clk), .rst(rst), .sclClk(sclClk), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .alarmStatus(alarmStatus), .alarmEvent(alarmEvent),
    .irqN(irqN), .cmdA(cmdA), .cmdB(cmdB), .cmdC(cmdC), .cmdE(cmdE), .cmdUpdate(cmdUpdate));
  isp_master isp_master_i (.sclClk(sclClk), .sdaDrv(sdaDrv), .sdaLine(sdaIn));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (cmdUpdate === 1'b1)
      updates++;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] expRd();
    if (ptr == SUB_D)
      return (irqM != 0) ? lat : alarmStatus;
    if (ptr inside {SUB_A, SUB_B, SUB_E} && wr[ptr] != 0)
      return 8'(pend[ptr]);
    if (ptr inside {SUB_A, SUB_B, SUB_C, SUB_E})
      return 8'(act[ptr]);
    return NO_DATA;
  endfunction
  task automatic wstart();
    isp_master_i.start();
    isp_master_i.wb(WR_ADDR, ack);
    chk({7'h00, ack}, 8'h00);
    pos = 0;
  endtask
  task automatic wbyte(input logic [7:0] b);
    isp_master_i.wb(b, ack);
    chk({7'h00, ack}, 8'h00);
    pos++;
    if (pos % 2 == 1)
      ptr = b;
    else if (ptr inside {SUB_A, SUB_B, SUB_C, SUB_E})
    begin
      pend[ptr] = b;
      wr[ptr] = 1;
    end
  endtask
  task automatic foreign();
    isp_master_i.start();
    isp_master_i.wb(8'hd0, ack);
    chk({7'h00, ack}, 8'h01);
  endtask
  task automatic rdtx();
    isp_master_i.start();
    isp_master_i.wb(RD_ADDR, ack);
    chk({7'h00, ack}, 8'h00);
    isp_master_i.rb(d, ack);
    chk(d, expRd());
    chk({7'h00, ack}, 8'h01);
    isp_master_i.rb(d, ack);
    chk(d, 8'hff);
  endtask
  task automatic cmds();
    chk(cmdA, 8'(act[SUB_A]));
    chk(cmdB, 8'(act[SUB_B]));
    chk(cmdC, 8'(act[SUB_C]));
    chk(cmdE, 8'(act[SUB_E]));
  endtask
  task automatic stopc();
    isp_master_i.stop();
    repeat (10) @(negedge sys_clk);
    stops++;
    chk({7'h00, sdaOut}, 8'h00);
    if (wr[SUB_E] != 0 && pend[SUB_E][0])
      irqM = 0;
    foreach (wr[i])
    begin
      if (wr[i] != 0)
        act[i] = pend[i];
      wr[i] = 0;
    end
    chk(8'(updates), 8'(stops));
    chk({7'h00, irqN}, (irqM != 0) ? 8'h00 : 8'h01);
    cmds();
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    alarmStatus = 8'h00;
    alarmEvent = 1'b0;
    ptr = PTR_RESET;
    lat = 8'h00;
    void'($urandom(37));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    cmds();
    chk({7'h00, irqN}, 8'h01);
    foreign();
    stopc();
    wstart();
    foreach (locs[i])
    begin
      wbyte(locs[i]);
      wbyte(8'($urandom));
    end
    stopc();
    foreach (locs[i])
    begin
      wstart();
      wbyte(locs[i]);
      wbyte(8'($urandom));
      wbyte(locs[i]);
      rdtx();
      cmds();
      foreign();
      rdtx();
      stopc();
      rdtx();
    end
    @(negedge sys_clk);
    alarmStatus = 8'($urandom);
    wstart();
    wbyte(SUB_D);
    rdtx();
    stopc();
    @(negedge sys_clk);
    alarmEvent = 1'b1;
    alarmStatus = 8'($urandom);
    lat = alarmStatus;
    irqM = 1;
    @(negedge sys_clk);
    alarmEvent = 1'b0;
    alarmStatus = 8'($urandom);
    @(negedge sys_clk);
    chk({7'h00, irqN}, 8'h00);
    rdtx();
    stopc();
    wstart();
    wbyte(SUB_E);
    wbyte(8'h01);
    wbyte(SUB_D);
    stopc();
    rdtx();
    stop_test();
  end
  // a hung handshake ends the run as a mismatch
  initial
  begin
    #3000000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
